/* hw/stc_consts.svh */
// register offsets, field positions, reset values and timing constants of the timer
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

`define STC_ADDR_W 8
`define STC_A_CTRL0 8'h00
`define STC_A_CTRL1 8'h04
`define STC_A_CNT_LO 8'h08
`define STC_A_CNT_HI 8'h0c
`define STC_A_CMPA_LO 8'h10
`define STC_A_CMPA_HI 8'h14
`define STC_A_STATUS 8'h18

`define STC_CTRL0_RST 8'h00
`define STC_CTRL1_RST 8'h00
`define STC_CMPA_RST 10'h000
`define STC_COUNT_ZERO 10'h000
`define STC_COUNT_ONE 10'h001
`define STC_COUNT_MAX 10'h3ff
`define STC_LOW_ZERO 7'h00
`define STC_PERIOD_FULL 3'h0

`define STC_MODE_CMP 2'h0
`define STC_MODE_CAP 2'h1
`define STC_MODE_PWM 2'h2
`define STC_MODE_TMR 2'h3

`define STC_IO_0 2'h0
`define STC_IO_1 2'h1
`define STC_IO_2 2'h2
`define STC_IO_3 2'h3

`define STC_CK_SYS_DIV4 3'h0
`define STC_CK_SYS 3'h1
`define STC_CK_H_DIV16 3'h2
`define STC_CK_H_DIV64 3'h3
`define STC_CK_SUB_A 3'h4
`define STC_CK_SUB_B 3'h5
`define STC_CK_EXT_RISE 3'h6
`define STC_CK_EXT_FALL 3'h7

`define STC_PRE_W 6
`define STC_PRE_DIV4 2'h3
`define STC_PRE_DIV16 4'hf
`define STC_PRE_DIV64 6'h3f
`define STC_PRE_ONE 6'h01
`define STC_PRE_ZERO 6'h00

`define STC_ST_FLAG_A 0
`define STC_ST_FLAG_P 1
`define STC_ST_LEVEL 2
`define STC_ST_RUN 3

`endif

/* hw/stc_pkg.sv */
// types shared by the timer modules
package stc_pkg;

	typedef logic [9:0] stc_count_t;

	typedef struct packed {
		logic pause;
		logic [2:0] clk_sel;
		logic run;
		logic [2:0] period;
	} stc_ctrl0_t;

	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] pin_fn;
		logic out_ctrl;
		logic polarity;
		logic duty_sel;
		logic clear_sel;
	} stc_ctrl1_t;

	typedef enum logic {
		STC_BUS_IDLE,
		STC_BUS_DATA
	} stc_bus_state_t;

endpackage : stc_pkg

/* hw/stc_tick_if.sv */
// clock selection and count tick between the timer core and its clock generator
`timescale 1ns/100ps
interface stc_tick_if;
	logic [2:0] sel;
	logic ext_rise;
	logic ext_fall;
	logic sub_rise;
	logic tick;

	modport gen (
		input sel,
		input ext_rise,
		input ext_fall,
		input sub_rise,
		output tick
	);

	modport core (
		output sel,
		output ext_rise,
		output ext_fall,
		output sub_rise,
		input tick
	);
endinterface : stc_tick_if

/* hw/stc_clkgen.sv */
// timer clock source selection and prescaler, producing a one-cycle count tick
`timescale 1ns/100ps
`include "stc_consts.svh"
module stc_clkgen (
	input wire logic clk_i,
	input wire logic rst_n_i,
	stc_tick_if.gen tick_if
);
	logic [`STC_PRE_W-1:0] pre_reg;
	logic tick_next;
	logic tick_reg;

	// high internal clock is taken as the system clock here, so one prescaler serves both
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_reg <= `STC_PRE_ZERO;
		end else begin
			pre_reg <= pre_reg + `STC_PRE_ONE;
		end
	end

	always_comb begin // [RULE8] [RULE21] [RULE9]
		case (tick_if.sel)
			`STC_CK_SYS_DIV4: tick_next = (pre_reg[1:0] == `STC_PRE_DIV4);
			`STC_CK_SYS: tick_next = 1'b1;
			`STC_CK_H_DIV16: tick_next = (pre_reg[3:0] == `STC_PRE_DIV16);
			`STC_CK_H_DIV64: tick_next = (pre_reg == `STC_PRE_DIV64);
			`STC_CK_SUB_A: tick_next = tick_if.sub_rise;
			`STC_CK_SUB_B: tick_next = tick_if.sub_rise;
			`STC_CK_EXT_RISE: tick_next = tick_if.ext_rise;
			`STC_CK_EXT_FALL: tick_next = tick_if.ext_fall;
			default: tick_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_reg <= 1'b0;
		end else begin
			tick_reg <= tick_next;
		end
	end

	assign tick_if.tick = tick_reg;

endmodule : stc_clkgen

/* hw/stc_top.sv */
// ten-bit standard timer core with an ahb-lite register slave
//
// Contract
// [RULE1] ten-bit up-counter advances once per selected timer clock, wraps on overflow
// [RULE2] period value is compared with the counter's top three bits only
// [RULE3] compare A value is compared with all ten counter bits
// [RULE4] two interrupt requests: compare A match and period match
// [RULE5] a compare match may clear the counter and change the output pin
// [RULE6] software cannot load the counter; run rising edge clears it
// [RULE7] overflow or selected match clears the counter and raises its request
// [RULE8] counter clock: divided system, divided high, sub clock or external pin
// [RULE9] external pin counts on rising or falling edge as configured
// [RULE10] external clock pin triggers the single pulse
// [RULE11] capture on rising, falling or both edges per pin function field
// [RULE12] second output pin is always the inverse of the primary output
// [RULE13] compare output mode sets high, sets low or toggles on match
// [RULE14] pwm waveform appears on the same output pin pair
// [RULE15] high bytes direct; low bytes via shared buffer moved on high access
// [RULE16] low write fills buffer; high write stores high and copies buffer low
// [RULE17] high read returns high and latches low into buffer; low read returns buffer
// [RULE18] software writes low then high, reads high then low
// [RULE19] five modes: compare, timer, capture, single pulse and pwm
// [RULE20] software routes the pin-shared functions before using the pins
// [RULE21] clock select codes map to the eight documented sources
// [RULE22] period zero gives 1024 clocks, otherwise value times 128 clocks
// [RULE23] mode field: 00 compare, 01 capture, 10 pwm or pulse, 11 timer
// [RULE24] run falling edge stops and holds the counter until run returns
// [RULE25] each request is a sticky flag kept until software clears it
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`include "stc_consts.svh"
module stc_top (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic ext_clock_pin_i,
	input wire logic capture_in_pin_i,
	input wire logic sub_clock_i,
	output logic timer_out_pin_o,
	output logic timer_out_inv_pin_o,
	output logic irq_cmp_a_o,
	output logic irq_period_o
);
	localparam int NPIN = 3;

	// reset release
	logic rst_q1_reg;
	logic rst_q2_reg;
	logic rst_n;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_q1_reg <= 1'b0;
			rst_q2_reg <= 1'b0;
		end else begin
			rst_q1_reg <= 1'b1;
			rst_q2_reg <= rst_q1_reg;
		end
	end

	assign rst_n = rst_q2_reg;

	// pin synchronisers: bit 0 external clock, bit 1 capture, bit 2 sub clock
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_q1_reg;
	logic [NPIN-1:0] pin_q2_reg;
	logic [NPIN-1:0] pin_q3_reg;
	logic [NPIN-1:0] pin_rise;
	logic [NPIN-1:0] pin_fall;

	assign pin_raw = {sub_clock_i, capture_in_pin_i, ext_clock_pin_i};

	genvar gp;
	generate
		for (gp = 0; gp < NPIN; gp++) begin : g_pin
			always_ff @(posedge clk_i or negedge rst_n) begin
				if (!rst_n) begin
					pin_q1_reg[gp] <= 1'b0;
					pin_q2_reg[gp] <= 1'b0;
					pin_q3_reg[gp] <= 1'b0;
				end else begin
					pin_q1_reg[gp] <= pin_raw[gp];
					pin_q2_reg[gp] <= pin_q1_reg[gp];
					pin_q3_reg[gp] <= pin_q2_reg[gp];
				end
			end
			assign pin_rise[gp] = pin_q2_reg[gp] & ~pin_q3_reg[gp];
			assign pin_fall[gp] = ~pin_q2_reg[gp] & pin_q3_reg[gp];
		end
	endgenerate

	// control and compare storage
	stc_pkg::stc_ctrl0_t ctrl0_reg;
	stc_pkg::stc_ctrl1_t ctrl1_reg;
	stc_pkg::stc_count_t cnt_reg;
	stc_pkg::stc_count_t cmpa_reg;
	logic [7:0] low_buf_reg;
	logic run_prev_reg;
	logic flag_a_reg;
	logic flag_p_reg;
	logic out_level_reg;
	logic pulse_reg;

	// clock generator
	stc_tick_if tick_bus ();

	assign tick_bus.sel = ctrl0_reg.clk_sel;
	assign tick_bus.ext_rise = pin_rise[0];
	assign tick_bus.ext_fall = pin_fall[0];
	assign tick_bus.sub_rise = pin_rise[2];

	stc_clkgen u_clkgen (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.tick_if(tick_bus.gen)
	);

	// counter control
	logic run_rise;
	logic count_en;
	logic step;
	stc_pkg::stc_count_t cnt_inc;
	logic p_hit;
	logic a_hit;
	logic p_evt;
	logic a_evt;
	logic cap_evt;
	logic is_pulse_mode;
	logic pulse_trig;

	assign run_rise = ctrl0_reg.run & ~run_prev_reg; // [RULE6]
	assign count_en = ctrl0_reg.run & ~ctrl0_reg.pause; // [RULE24]
	assign step = tick_bus.tick & count_en;
	assign cnt_inc = cnt_reg + `STC_COUNT_ONE; // [RULE1]
	assign is_pulse_mode = (ctrl1_reg.mode == `STC_MODE_PWM) && (ctrl1_reg.pin_fn == `STC_IO_3);

	// period zero lets the counter run the full 1024 clocks to overflow
	always_comb begin // [RULE2] [RULE22]
		if (ctrl0_reg.period == `STC_PERIOD_FULL) begin
			p_hit = (cnt_reg == `STC_COUNT_MAX);
		end else begin
			p_hit = (cnt_inc[9:7] == ctrl0_reg.period) && (cnt_inc[6:0] == `STC_LOW_ZERO);
		end
	end

	// capture mode reuses compare A as the capture register, so no A match there
	assign a_hit = (cnt_inc == cmpa_reg) && (ctrl1_reg.mode != `STC_MODE_CAP); // [RULE3]
	assign p_evt = step & p_hit;
	assign a_evt = step & a_hit;

	always_comb begin // [RULE11]
		cap_evt = 1'b0;
		if (ctrl1_reg.mode == `STC_MODE_CAP && count_en) begin
			case (ctrl1_reg.pin_fn)
				`STC_IO_0: cap_evt = pin_rise[1];
				`STC_IO_1: cap_evt = pin_fall[1];
				`STC_IO_2: cap_evt = pin_rise[1] | pin_fall[1];
				default: cap_evt = 1'b0;
			endcase
		end
	end

	assign pulse_trig = is_pulse_mode && count_en && pin_rise[0] && !pulse_reg; // [RULE10]

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			run_prev_reg <= 1'b0;
		end else begin
			run_prev_reg <= ctrl0_reg.run;
		end
	end

	// clear on run rise wins over counting in the same cycle
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= `STC_COUNT_ZERO;
		end else if (run_rise || pulse_trig) begin
			cnt_reg <= `STC_COUNT_ZERO; // [RULE6] [RULE10]
		end else if (step) begin
			if (ctrl1_reg.clear_sel ? a_hit : p_hit) begin
				cnt_reg <= `STC_COUNT_ZERO; // [RULE5] [RULE7]
			end else begin
				cnt_reg <= cnt_inc; // [RULE1]
			end
		end
	end

	// sticky requests; a hardware set beats a software clear
	logic clr_a;
	logic clr_p;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			flag_a_reg <= 1'b0;
		end else if (a_evt || cap_evt) begin
			flag_a_reg <= 1'b1; // [RULE4] [RULE25] [RULE7]
		end else if (clr_a) begin
			flag_a_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			flag_p_reg <= 1'b0;
		end else if (p_evt) begin
			flag_p_reg <= 1'b1; // [RULE4] [RULE25] [RULE7]
		end else if (clr_p) begin
			flag_p_reg <= 1'b0;
		end
	end

	// single pulse: starts on trigger or run rise, ends at compare A match
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pulse_reg <= 1'b0;
		end else if (!is_pulse_mode || !ctrl0_reg.run) begin
			pulse_reg <= 1'b0;
		end else if (a_evt) begin
			pulse_reg <= 1'b0;
		end else if (run_rise || pulse_trig) begin
			pulse_reg <= 1'b1; // [RULE10]
		end
	end

	// output level before polarity; timer mode simply holds it
	logic pwm_active;

	assign pwm_active = (cnt_reg < cmpa_reg);

	always_ff @(posedge clk_i or negedge rst_n) begin // [RULE19] [RULE23]
		if (!rst_n) begin
			out_level_reg <= 1'b0;
		end else if (run_rise) begin
			out_level_reg <= (ctrl1_reg.mode == `STC_MODE_PWM) ? ~ctrl1_reg.out_ctrl
				: ctrl1_reg.out_ctrl;
		end else begin
			case (ctrl1_reg.mode)
				`STC_MODE_CMP: begin
					if (a_evt) begin
						case (ctrl1_reg.pin_fn) // [RULE13] [RULE5]
							`STC_IO_1: out_level_reg <= 1'b0;
							`STC_IO_2: out_level_reg <= 1'b1;
							`STC_IO_3: out_level_reg <= ~out_level_reg;
							default: out_level_reg <= out_level_reg;
						endcase
					end
				end
				`STC_MODE_PWM: begin
					case (ctrl1_reg.pin_fn) // [RULE14]
						`STC_IO_0: out_level_reg <= ~ctrl1_reg.out_ctrl;
						`STC_IO_1: out_level_reg <= ctrl1_reg.out_ctrl;
						`STC_IO_2: out_level_reg <= ctrl0_reg.run
							? (pwm_active ~^ ctrl1_reg.out_ctrl) : out_level_reg;
						default: out_level_reg <= pulse_reg ~^ ctrl1_reg.out_ctrl;
					endcase
				end
				default: out_level_reg <= out_level_reg;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			timer_out_pin_o <= 1'b0;
			timer_out_inv_pin_o <= 1'b1;
		end else begin
			timer_out_pin_o <= out_level_reg ^ ctrl1_reg.polarity; // [RULE14]
			timer_out_inv_pin_o <= ~(out_level_reg ^ ctrl1_reg.polarity); // [RULE12]
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_cmp_a_o <= 1'b0;
			irq_period_o <= 1'b0;
		end else begin
			irq_cmp_a_o <= flag_a_reg; // [RULE4]
			irq_period_o <= flag_p_reg; // [RULE4]
		end
	end

	// ahb-lite slave: one wait state per transfer, so a read sees any earlier write
	stc_pkg::stc_bus_state_t bus_state_reg;
	logic [`STC_ADDR_W-1:0] addr_reg;
	logic write_reg;
	logic take;
	logic data_wr;
	logic data_rd;

	assign take = hsel_i & htrans_i[1] & hready_i;
	assign data_wr = (bus_state_reg == stc_pkg::STC_BUS_DATA) & write_reg;
	assign data_rd = (bus_state_reg == stc_pkg::STC_BUS_DATA) & ~write_reg;
	assign clr_a = data_wr && addr_reg == `STC_A_STATUS && hwdata_i[`STC_ST_FLAG_A];
	assign clr_p = data_wr && addr_reg == `STC_A_STATUS && hwdata_i[`STC_ST_FLAG_P];

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			bus_state_reg <= stc_pkg::STC_BUS_IDLE;
			addr_reg <= '0;
			write_reg <= 1'b0;
			hreadyout_o <= 1'b1;
		end else begin
			case (bus_state_reg)
				stc_pkg::STC_BUS_IDLE: begin
					if (take) begin
						bus_state_reg <= stc_pkg::STC_BUS_DATA;
						addr_reg <= haddr_i[`STC_ADDR_W-1:0];
						write_reg <= hwrite_i;
						hreadyout_o <= 1'b0;
					end
				end
				stc_pkg::STC_BUS_DATA: begin
					bus_state_reg <= stc_pkg::STC_BUS_IDLE;
					hreadyout_o <= 1'b1;
				end
				default: begin
					bus_state_reg <= stc_pkg::STC_BUS_IDLE;
					hreadyout_o <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hresp_o <= 1'b0;
		end else begin
			hresp_o <= 1'b0;
		end
	end

	// control writes; mode changes are only safe with the counter stopped
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl0_reg <= `STC_CTRL0_RST;
			ctrl1_reg <= `STC_CTRL1_RST;
		end else if (data_wr) begin
			if (addr_reg == `STC_A_CTRL0) begin
				ctrl0_reg <= hwdata_i[7:0]; // [RULE8] [RULE24]
			end
			if (addr_reg == `STC_A_CTRL1) begin
				ctrl1_reg <= hwdata_i[7:0]; // [RULE23]
			end
		end
	end

	// compare A: high write pulls the buffer in; capture loads the live count
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cmpa_reg <= `STC_CMPA_RST;
		end else if (cap_evt) begin
			cmpa_reg <= cnt_reg; // [RULE11]
		end else if (data_wr && addr_reg == `STC_A_CMPA_HI) begin
			cmpa_reg <= {hwdata_i[1:0], low_buf_reg}; // [RULE16]
		end
	end

	// shared low-byte buffer; counter low writes are dropped, the counter is read only
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			low_buf_reg <= 8'h00;
		end else if (data_wr && addr_reg == `STC_A_CMPA_LO) begin
			low_buf_reg <= hwdata_i[7:0]; // [RULE15] [RULE16]
		end else if (data_rd && addr_reg == `STC_A_CNT_HI) begin
			low_buf_reg <= cnt_reg[7:0]; // [RULE17]
		end else if (data_rd && addr_reg == `STC_A_CMPA_HI) begin
			low_buf_reg <= cmpa_reg[7:0]; // [RULE17]
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_o <= 32'h0000_0000;
		end else if (data_rd) begin
			case (addr_reg)
				`STC_A_CTRL0: hrdata_o <= {24'h00_0000, ctrl0_reg};
				`STC_A_CTRL1: hrdata_o <= {24'h00_0000, ctrl1_reg};
				`STC_A_CNT_LO: hrdata_o <= {24'h00_0000, low_buf_reg}; // [RULE17]
				`STC_A_CNT_HI: hrdata_o <= {30'h0000_0000, cnt_reg[9:8]}; // [RULE15]
				`STC_A_CMPA_LO: hrdata_o <= {24'h00_0000, low_buf_reg}; // [RULE17]
				`STC_A_CMPA_HI: hrdata_o <= {30'h0000_0000, cmpa_reg[9:8]}; // [RULE15]
				`STC_A_STATUS: hrdata_o <= {28'h000_0000, ctrl0_reg.run, out_level_reg,
					flag_p_reg, flag_a_reg};
				default: hrdata_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule : stc_top

/* bench/stc_top_sva.sv */
// bus timing, output pin and interrupt checks seen from the timer top ports
`timescale 1ns/100ps
`include "stc_consts.svh"
module stc_top_sva (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic timer_out_pin_o,
	input wire logic timer_out_inv_pin_o,
	input wire logic irq_cmp_a_o,
	input wire logic irq_period_o
);
	logic taken;
	logic rd_taken;
	logic [5:0] stat_wr_q;
	assign taken = hsel_i && htrans_i[1] && hready_i;
	assign rd_taken = taken && !hwrite_i;
	// a flag clear reaches the request output a few cycles after its address phase
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stat_wr_q <= 6'h00;
		end else begin
			stat_wr_q <= {stat_wr_q[4:0], taken && hwrite_i && (haddr_i[7:0] == `STC_A_STATUS)};
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence one_wait;
		!hreadyout_o ##1 hreadyout_o;
	endsequence
	a_one_wait: assert property (taken |=> one_wait)
		else $error("transfer without exactly one wait state");
	a_ready_idle: assert property (!taken |=> hreadyout_o)
		else $error("wait state without a transfer");
	a_resp_okay: assert property (hresp_o == 1'b0)
		else $error("error response seen");
	a_inv_pin: assert property (timer_out_inv_pin_o != timer_out_pin_o)
		else $error("inverted pin equals primary pin");
	a_unmapped_zero: assert property ((rd_taken && haddr_i[7:0] > `STC_A_STATUS)
		|=> ##1 hrdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_upper_zero: assert property (rd_taken |=> ##1 hrdata_o[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_rdata_hold: assert property ($changed(hrdata_o) |-> $past(rd_taken, 2))
		else $error("read data changed without a read");
	a_irq_a_sticky: assert property ($fell(irq_cmp_a_o) |-> (|stat_wr_q))
		else $error("compare a request dropped without a clear");
	a_irq_p_sticky: assert property ($fell(irq_period_o) |-> (|stat_wr_q))
		else $error("period request dropped without a clear");
endmodule : stc_top_sva

bind stc_top stc_top_sva u_sva (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
	.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
	.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
	.timer_out_pin_o(timer_out_pin_o), .timer_out_inv_pin_o(timer_out_inv_pin_o),
	.irq_cmp_a_o(irq_cmp_a_o), .irq_period_o(irq_period_o));

/* bench/stc_pin_model.sv */
// pin-side stand-in: external clock, capture input and sub clock sources
`timescale 1ns/100ps
module stc_pin_model (
	input wire logic clk_i,
	output logic ext_clock_pin_o,
	output logic capture_in_pin_o,
	output logic sub_clock_o
);
	logic [3:0] sub_div = 4'h0;
	// pins are treated as routed to the timer from time zero
	initial begin
		ext_clock_pin_o = 1'b0;
		capture_in_pin_o = 1'b0;
	end
	// slow clock runs free, one rising edge every 16 system cycles
	always @(posedge clk_i) begin
		sub_div <= sub_div + 4'h1;
	end
	assign sub_clock_o = sub_div[3];
	// pulses wide enough to survive the two-stage synchroniser
	task automatic ext_pulses(input int n);
		repeat (n) begin
			@(posedge clk_i);
			ext_clock_pin_o <= 1'b1;
			repeat (5) @(posedge clk_i);
			ext_clock_pin_o <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask : ext_pulses
	task automatic cap_pulse();
		@(posedge clk_i);
		capture_in_pin_o <= 1'b1;
		repeat (5) @(posedge clk_i);
		capture_in_pin_o <= 1'b0;
		repeat (5) @(posedge clk_i);
	endtask : cap_pulse
endmodule : stc_pin_model

/* bench/test_standard_timer_module.sv */
// self-checking bench for the timer core through its ahb-lite registers
`timescale 1ns/100ps
`include "stc_consts.svh"
module test_standard_timer_module;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, ext_pin, cap_pin, sub_clk, out_pin, out_inv, irq_a, irq_p;
	int n_fail = 0;
	int samples_checked = 0;
	int cycles = 0;
	int div [8] = '{4, 1, 16, 64, 16, 16, 0, 0};
	stc_top dut (.clk_i(clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
		.ext_clock_pin_i(ext_pin), .capture_in_pin_i(cap_pin), .sub_clock_i(sub_clk),
		.timer_out_pin_o(out_pin), .timer_out_inv_pin_o(out_inv), .irq_cmp_a_o(irq_a),
		.irq_period_o(irq_p));
	stc_pin_model pins (.clk_i(clk), .ext_clock_pin_o(ext_pin), .capture_in_pin_o(cap_pin),
		.sub_clock_o(sub_clk));
	initial begin
		forever begin
			#5 clk = ~clk;
		end
	end
	task automatic report_and_stop();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	// ready and read data are taken at the edge itself, before that edge's updates land
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] x;
		bus(1'b1, a, {24'h0, d}, x);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		bus(1'b0, a, 32'h0, d);
	endtask : rd
	task automatic rdcnt(output logic [9:0] v);
		logic [31:0] hi, lo;
		rd(`STC_A_CNT_HI, hi);
		rd(`STC_A_CNT_LO, lo);
		v = {hi[1:0], lo[7:0]};
	endtask : rdcnt
	task automatic wait_irq(input int which, input int lim, output int n);
		n = 0;
		while (((which == 0) ? irq_a : irq_p) !== 1'b1 && n < lim) begin
			cyc(1);
			n++;
		end
		check("irq raised", (which == 0) ? irq_a : irq_p, 1'b1);
	endtask : wait_irq
	function automatic logic [7:0] ctrl0(input logic [2:0] ck, input logic run, input logic [2:0] p);
		return {1'b0, ck, run, p};
	endfunction : ctrl0
	initial begin
		logic [31:0] d;
		logic [9:0] c0;
		int n, e;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		cyc(3);
		check("pins at reset", {out_pin, out_inv, irq_a, irq_p}, 4'h4);
		wr(8'h1c, 8'hff);
		for (int a = 0; a < 8'h20; a += 4) begin
			rd(a[7:0], d);
			check("reset read", d, 32'h0);
		end
		wr(`STC_A_CNT_LO, 8'h55);
		wr(`STC_A_CNT_HI, 8'h03);
		rdcnt(c0);
		check("counter not loadable", c0, 10'h000);
		wr(`STC_A_CMPA_LO, 8'h34);
		wr(`STC_A_CMPA_HI, 8'h02);
		rd(`STC_A_CMPA_HI, d);
		check("cmpa high", d, 32'h2);
		rd(`STC_A_CMPA_LO, d);
		check("cmpa low", d, 32'h34);
		rd(`STC_A_CNT_HI, d);
		rd(`STC_A_CMPA_LO, d);
		check("shared buffer", d, 32'h0);
		wr(`STC_A_CTRL1, 8'hc0);
		for (int k = 0; k < 8; k++) begin
			wr(`STC_A_CTRL0, ctrl0(k[2:0], 1'b1, 3'h0));
			cyc(256);
			wr(`STC_A_CTRL0, ctrl0(k[2:0], 1'b0, 3'h0));
			rdcnt(c0);
			e = (div[k] == 0) ? 0 : 258 / div[k];
			n = int'(c0) - e;
			check("clock select count", (n < -3 || n > 3) ? c0 : e, e);
		end
		for (int k = 6; k < 8; k++) begin
			wr(`STC_A_CTRL0, ctrl0(k[2:0], 1'b1, 3'h0));
			pins.ext_pulses(5);
			cyc(8);
			wr(`STC_A_CTRL0, ctrl0(k[2:0], 1'b0, 3'h0));
			rdcnt(c0);
			check("ext edge count", c0, 10'h005);
			cyc(20);
			rdcnt(c0);
			check("count held", c0, 10'h005);
		end
		wr(`STC_A_CMPA_LO, 8'h20);
		wr(`STC_A_CMPA_HI, 8'h00);
		for (int io = 1; io < 4; io++) begin
			wr(`STC_A_CTRL1, {2'b00, io[1:0], io == 1, 3'h1});
			wr(`STC_A_STATUS, 8'h03);
			wr(`STC_A_CTRL0, ctrl0(3'h1, 1'b1, 3'h0));
			cyc(3);
			check("level after run", out_pin, io == 1);
			wait_irq(0, 60, n);
			cyc(2);
			check("level after match", out_pin, io != 1);
			wr(`STC_A_CTRL0, ctrl0(3'h1, 1'b0, 3'h0));
			rdcnt(c0);
			check("cleared by match", c0 < 10'h020, 1'b1);
			rd(`STC_A_STATUS, d);
			check("sticky flag a", d[1:0], 2'h1);
		end
		wr(`STC_A_CTRL1, 8'hc0);
		for (int p = 1; p >= 0; p--) begin
			wr(`STC_A_STATUS, 8'h03);
			wr(`STC_A_CTRL0, ctrl0(3'h1, 1'b1, p[2:0]));
			wait_irq(1, 1100, n);
			e = (p == 0) ? 1024 : 128;
			check("period length", (n < e - 8 || n > e + 8) ? n : e, e);
			wr(`STC_A_CTRL0, ctrl0(3'h1, 1'b0, p[2:0]));
		end
		for (int io = 0; io < 4; io++) begin
			wr(`STC_A_CTRL1, {2'b01, io[1:0], 4'h0});
			wr(`STC_A_STATUS, 8'h03);
			wr(`STC_A_CTRL0, ctrl0(3'h1, 1'b1, 3'h0));
			pins.cap_pulse();
			cyc(8);
			rd(`STC_A_STATUS, d);
			check("capture flag", d[0], io != 3);
			wr(`STC_A_CTRL0, ctrl0(3'h1, 1'b0, 3'h0));
		end
		wr(`STC_A_CMPA_LO, 8'h40);
		wr(`STC_A_CMPA_HI, 8'h00);
		wr(`STC_A_CTRL1, 8'ha8);
		wr(`STC_A_CTRL0, ctrl0(3'h1, 1'b1, 3'h1));
		cyc(10);
		n = 0;
		repeat (128) begin
			cyc(1);
			n += (out_pin === 1'b1);
		end
		check("pwm high cycles", (n < 61 || n > 67) ? n : 64, 64);
		// single pulse, active high: idle until the pin edge, then one compare A span
		wr(`STC_A_CTRL1, 8'hb8);
		cyc(4);
		check("pulse idle", out_pin, 1'b0);
		pins.ext_pulses(1);
		check("pulse started", out_pin, 1'b1);
		cyc(80);
		check("pulse ended", out_pin, 1'b0);
		wr(`STC_A_CTRL1, 8'hbc);
		cyc(3);
		check("polarity pair", {out_pin, out_inv}, 2'h2);
		report_and_stop();
	end
endmodule : test_standard_timer_module
